// file: logic/ilsa_unit.sv
`timescale 1ns/1ps
module ilsa_unit (
    input wire logic clk_sys_in, // System clock, 100 MHz.
    input wire logic rstn_in, // Asynchronous reset, active low.
    input wire logic instr_valid_in, // Instruction word is valid this cycle.
    input wire logic [ilsa_pkg::ILSA_XLEN-1:0] instr_word_in, // Instruction word.
    input wire logic [ilsa_pkg::ILSA_XLEN-1:0] first_source_data_in, // First source value.
    input wire logic [ilsa_pkg::ILSA_XLEN-1:0] second_source_data_in, // Second source value.
    output logic [ilsa_pkg::ILSA_REG_W-1:0] first_source_reg_out, // First source index.
    output logic [ilsa_pkg::ILSA_REG_W-1:0] second_source_reg_out, // Second source index.
    output logic [ilsa_pkg::ILSA_XLEN-1:0] result_out, // Result for destination.
    output logic [ilsa_pkg::ILSA_REG_W-1:0] dest_reg_out, // Destination index.
    output logic write_en_out, // Destination write pulse.
    output logic done_out, // Instruction retired pulse.
    output logic illegal_out, // Unsupported arithmetic-format encoding pulse.
    output logic cc_update_out, // Condition codes changed pulse.
    output logic [3:0] cond_codes_out // Held condition codes N Z V C.
);
    import ilsa_pkg::*;

    logic [1:0] rst_sync_q;
    logic rst_n;
    ilsa_state_t state_q;
    ilsa_state_t state_d;

    logic [1:0] format_opcode;
    logic [2:0] format2_opcode_field;
    logic [5:0] extended_opcode_field;
    logic [ILSA_REG_W-1:0] dest_field;
    logic [ILSA_REG_W-1:0] first_source_reg;
    logic [ILSA_REG_W-1:0] second_source_reg;
    logic operand_select;
    logic [ILSA_SIMM_MSB:0] signed_immediate_field;
    logic [ILSA_HIGH_IMM_MSB:0] high_immediate_field;
    logic [ILSA_XLEN-1:0] op_a;
    logic [ILSA_XLEN-1:0] op_b;
    logic [ILSA_SHAMT_W-1:0] shift_amount;
    logic shift_left;
    logic shift_arith;
    logic [ILSA_XLEN-1:0] shift_result;
    logic [ILSA_XLEN:0] sum_wide;
    logic carry_bit;

    // Reset release passes two flip-flops before the logic sees it.
    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    // Instruction fields at their fixed positions.
    assign format_opcode = instr_word_in[ILSA_OP_MSB:ILSA_OP_LSB];
    assign dest_field = instr_word_in[ILSA_RD_MSB:ILSA_RD_LSB];
    assign format2_opcode_field = instr_word_in[ILSA_FMT2_OPC_MSB:ILSA_FMT2_OPC_LSB];
    assign extended_opcode_field = instr_word_in[ILSA_XOPC_MSB:ILSA_XOPC_LSB];
    assign first_source_reg = instr_word_in[ILSA_SRC1_MSB:ILSA_SRC1_LSB];
    assign operand_select = instr_word_in[ILSA_IBIT];
    assign signed_immediate_field = instr_word_in[ILSA_SIMM_MSB:ILSA_SIMM_LSB];
    assign second_source_reg = instr_word_in[ILSA_SRC2_MSB:ILSA_SRC2_LSB];
    assign high_immediate_field = instr_word_in[ILSA_HIGH_IMM_MSB:ILSA_HIGH_IMM_LSB];
    assign first_source_reg_out = first_source_reg;
    assign second_source_reg_out = second_source_reg;

    // Operands; register zero always reads as zero.
    always_comb begin
        op_a = (first_source_reg == '0) ? '0 : first_source_data_in;
        if (operand_select) begin
            op_b = {{(ILSA_XLEN-ILSA_SIMM_MSB-1){signed_immediate_field[ILSA_SIMM_MSB]}},
                signed_immediate_field};
        end else begin
            op_b = (second_source_reg == '0) ? '0 : second_source_data_in;
        end
    end

    // Shift count is the low five bits of the operand, immediate or register.
    assign shift_amount = op_b[ILSA_SHAMT_W-1:0];
    assign shift_left = (extended_opcode_field == ILSA_XOPC_SHL);
    assign shift_arith = (extended_opcode_field == ILSA_XOPC_SHRA);

    ilsa_shifter #(
        .WIDTH(ILSA_XLEN),
        .AMT_W(ILSA_SHAMT_W)
    ) u_shifter (
        .value_in(op_a),
        .amount_in(shift_amount),
        .left_in(shift_left),
        .arith_in(shift_arith),
        .value_out(shift_result)
    );

    // The carry added by the carry variants is the held C flag.
    assign carry_bit = state_q.cc[ILSA_CC_C] &
        extended_opcode_field[ILSA_CARRY_SEL_BIT];
    assign sum_wide = {1'b0, op_a} + {1'b0, op_b} + {{ILSA_XLEN{1'b0}}, carry_bit};

    // Decode and execute one instruction into the next state.
    always_comb begin
        logic [ILSA_XLEN-1:0] res;
        logic writes;
        logic sets_cc;
        logic is_add;
        logic bad;
        logic [3:0] cc_new;
        res = '0;
        writes = 1'b0;
        sets_cc = 1'b0;
        is_add = 1'b0;
        bad = 1'b0;
        cc_new = state_q.cc;
        state_d = state_q;
        state_d.wr_en = 1'b0;
        state_d.done = 1'b0;
        state_d.illegal = 1'b0;
        state_d.cc_upd = 1'b0;
        if (instr_valid_in) begin
            if (format_opcode == ILSA_OP_FMT2 &&
                format2_opcode_field == ILSA_FMT2_SETHIGH) begin
                // Condition codes are left alone here.
                res = {high_immediate_field, {ILSA_LOW_ZERO_W{1'b0}}};
                writes = 1'b1;
            end else if (format_opcode == ILSA_OP_ARITH) begin
                // Flag forms differ from plain forms only in bit four.
                unique case (extended_opcode_field & ~ILSA_FLAG_MASK)
                    ILSA_XOPC_ADD, ILSA_XOPC_ADDC: begin
                        res = sum_wide[ILSA_XLEN-1:0];
                        writes = 1'b1;
                        is_add = 1'b1;
                        sets_cc = extended_opcode_field[ILSA_FLAG_BIT];
                    end
                    ILSA_XOPC_AND: begin
                        res = op_a & op_b;
                        writes = 1'b1;
                        sets_cc = extended_opcode_field[ILSA_FLAG_BIT];
                    end
                    ILSA_XOPC_OR: begin
                        res = op_a | op_b;
                        writes = 1'b1;
                        sets_cc = extended_opcode_field[ILSA_FLAG_BIT];
                    end
                    ILSA_XOPC_XOR: begin
                        res = op_a ^ op_b;
                        writes = 1'b1;
                        sets_cc = extended_opcode_field[ILSA_FLAG_BIT];
                    end
                    ILSA_XOPC_ANDNOT: begin
                        res = op_a & ~op_b;
                        writes = 1'b1;
                        sets_cc = extended_opcode_field[ILSA_FLAG_BIT];
                    end
                    ILSA_XOPC_ORNOT: begin
                        res = op_a | ~op_b;
                        writes = 1'b1;
                        sets_cc = extended_opcode_field[ILSA_FLAG_BIT];
                    end
                    ILSA_XOPC_XORNOT: begin
                        res = op_a ^ ~op_b;
                        writes = 1'b1;
                        sets_cc = extended_opcode_field[ILSA_FLAG_BIT];
                    end
                    default: begin
                        // Shifts have no flag form; zero count passes op_a through.
                        if (extended_opcode_field == ILSA_XOPC_SHL ||
                            extended_opcode_field == ILSA_XOPC_SHRL ||
                            extended_opcode_field == ILSA_XOPC_SHRA) begin
                            if (operand_select &&
                                instr_word_in[ILSA_SHRSV_MSB:ILSA_SHRSV_LSB] != '0) begin
                                bad = 1'b1;
                            end else begin
                                res = shift_result;
                                writes = 1'b1;
                            end
                        end else begin
                            bad = 1'b1;
                        end
                    end
                endcase
            end
            // Condition codes: N and Z from the result, V and C from adds only.
            if (sets_cc) begin
                cc_new[ILSA_CC_N] = res[ILSA_XLEN-1];
                cc_new[ILSA_CC_Z] = (res == '0);
                cc_new[ILSA_CC_V] = is_add & (op_a[ILSA_XLEN-1] == op_b[ILSA_XLEN-1]) &
                    (res[ILSA_XLEN-1] != op_a[ILSA_XLEN-1]);
                cc_new[ILSA_CC_C] = is_add & sum_wide[ILSA_XLEN];
            end
            state_d.cc = cc_new;
            state_d.cc_upd = sets_cc;
            state_d.result = res;
            state_d.dest = dest_field;
            // Writes to register zero are discarded, so the zero set-high is a no-op.
            state_d.wr_en = writes & (dest_field != '0);
            state_d.done = writes;
            state_d.illegal = bad;
        end
    end

    // All block state except the reset synchronizer is registered as one word.
    always_ff @(posedge clk_sys_in or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= '{result: '0, dest: '0, wr_en: 1'b0, done: 1'b0,
                         illegal: 1'b0, cc_upd: 1'b0, cc: ILSA_CC_RESET};
        end else begin
            state_q <= state_d;
        end
    end

    // Outputs come straight from the state register.
    assign result_out = state_q.result;
    assign dest_reg_out = state_q.dest;
    assign write_en_out = state_q.wr_en;
    assign done_out = state_q.done;
    assign illegal_out = state_q.illegal;
    assign cc_update_out = state_q.cc_upd;
    assign cond_codes_out = state_q.cc;

endmodule : ilsa_unit

// file: logic/ilsa_pkg.sv
// Contract
// - Set-high writes immediate high, low ten zero.
// - Set-high is format 00 with opcode 100.
// - Set-high leaves condition codes unchanged.
// - Zero-destination zero-immediate set-high changes nothing.
// - Logical ops use register or sign-extended immediate.
// - Only flag-setting logical forms update condition codes.
// - Logical opcodes differ from flag forms in bit four.
// - And-not and or-not invert the second operand.
// - Xor-not xors first with inverted second operand.
// - Shift amount is low five bits or count.
// - Shifts left, right logical, right arithmetic fill.
// - Zero shift amount passes first source unchanged.
// - Shifts write result and keep condition codes.
// - Shift opcodes fixed; immediate bits twelve-five zero.
// - Addition variants decoded from their four opcodes.
// - Add sums first source with chosen operand.
// - Add-with-carry also adds the carry bit.
// - Flag adds update codes and detect overflow.
package ilsa_pkg;

    localparam int unsigned ILSA_XLEN = 32;
    localparam int unsigned ILSA_REG_W = 5;
    localparam int unsigned ILSA_SHAMT_W = 5;

    // Instruction field positions.
    localparam int unsigned ILSA_OP_MSB = 31;
    localparam int unsigned ILSA_OP_LSB = 30;
    localparam int unsigned ILSA_RD_MSB = 29;
    localparam int unsigned ILSA_RD_LSB = 25;
    localparam int unsigned ILSA_FMT2_OPC_MSB = 24;
    localparam int unsigned ILSA_FMT2_OPC_LSB = 22;
    localparam int unsigned ILSA_XOPC_MSB = 24;
    localparam int unsigned ILSA_XOPC_LSB = 19;
    localparam int unsigned ILSA_SRC1_MSB = 18;
    localparam int unsigned ILSA_SRC1_LSB = 14;
    localparam int unsigned ILSA_IBIT = 13;
    localparam int unsigned ILSA_SIMM_MSB = 12;
    localparam int unsigned ILSA_SIMM_LSB = 0;
    localparam int unsigned ILSA_SRC2_MSB = 4;
    localparam int unsigned ILSA_SRC2_LSB = 0;
    localparam int unsigned ILSA_HIGH_IMM_MSB = 21;
    localparam int unsigned ILSA_HIGH_IMM_LSB = 0;
    localparam int unsigned ILSA_SHRSV_MSB = 12;
    localparam int unsigned ILSA_SHRSV_LSB = 5;
    localparam int unsigned ILSA_FLAG_BIT = 4;
    localparam int unsigned ILSA_CARRY_SEL_BIT = 3;
    localparam int unsigned ILSA_LOW_ZERO_W = 10;

    // Primary and secondary opcode values.
    localparam logic [1:0] ILSA_OP_FMT2 = 2'h0;
    localparam logic [1:0] ILSA_OP_ARITH = 2'h2;
    localparam logic [2:0] ILSA_FMT2_SETHIGH = 3'h4;

    // Extended opcodes, plain forms plus the two flag adds; flag forms set bit four.
    localparam logic [5:0] ILSA_XOPC_ADD = 6'h00;
    localparam logic [5:0] ILSA_XOPC_ADDCC = 6'h10;
    localparam logic [5:0] ILSA_XOPC_ADDC = 6'h08;
    localparam logic [5:0] ILSA_XOPC_ADDCCC = 6'h18;
    localparam logic [5:0] ILSA_XOPC_AND = 6'h01;
    localparam logic [5:0] ILSA_XOPC_OR = 6'h02;
    localparam logic [5:0] ILSA_XOPC_XOR = 6'h03;
    localparam logic [5:0] ILSA_XOPC_ANDNOT = 6'h05;
    localparam logic [5:0] ILSA_XOPC_ORNOT = 6'h06;
    localparam logic [5:0] ILSA_XOPC_XORNOT = 6'h07;
    localparam logic [5:0] ILSA_XOPC_SHL = 6'h25;
    localparam logic [5:0] ILSA_XOPC_SHRL = 6'h26;
    localparam logic [5:0] ILSA_XOPC_SHRA = 6'h27;
    localparam logic [5:0] ILSA_FLAG_MASK = 6'h10;

    // Condition code bit positions within the four-bit group.
    localparam int unsigned ILSA_CC_N = 3;
    localparam int unsigned ILSA_CC_Z = 2;
    localparam int unsigned ILSA_CC_V = 1;
    localparam int unsigned ILSA_CC_C = 0;
    localparam logic [3:0] ILSA_CC_RESET = 4'h0;

    typedef struct packed {
        logic [ILSA_XLEN-1:0] result;
        logic [ILSA_REG_W-1:0] dest;
        logic wr_en;
        logic done;
        logic illegal;
        logic cc_upd;
        logic [3:0] cc;
    } ilsa_state_t;

endpackage : ilsa_pkg

// file: logic/ilsa_shifter.sv
`timescale 1ns/1ps
module ilsa_shifter #(
    parameter int unsigned WIDTH = 32,
    parameter int unsigned AMT_W = 5
) (
    input wire logic [WIDTH-1:0] value_in, // Value to shift.
    input wire logic [AMT_W-1:0] amount_in, // Shift count.
    input wire logic left_in, // High shifts left.
    input wire logic arith_in, // High fills right shifts with sign.
    output logic [WIDTH-1:0] value_out // Shifted value.
);

    logic fill;

    // Vacated bits take zero, or the sign bit for an arithmetic right shift.
    always_comb begin
        fill = arith_in & value_in[WIDTH-1];
        if (left_in) begin
            value_out = value_in << amount_in;
        end else begin
            // The fill word enters from the top; the low half is the result.
            value_out = WIDTH'({{WIDTH{fill}}, value_in} >> amount_in);
        end
    end

endmodule : ilsa_shifter

// file: logic/ilsa_unit_tail.sv
`timescale 1ns/1ps

// file: tb/ilsa_unit_assertions.sv
`timescale 1ns/1ps
module ilsa_unit_checker
    import ilsa_pkg::*;
(
    input wire logic clk_sys_in, // Clock.
    input wire logic rstn_in, // Reset, active low.
    input wire logic instr_valid_in, // Word valid.
    input wire logic [31:0] instr_word_in, // Word.
    input wire logic [31:0] first_source_data_in, // First operand.
    input wire logic [31:0] second_source_data_in, // Second operand.
    input wire logic [4:0] first_source_reg_out, // First index.
    input wire logic [4:0] second_source_reg_out, // Second index.
    input wire logic [31:0] result_out, // Result.
    input wire logic [4:0] dest_reg_out, // Destination.
    input wire logic write_en_out, // Write pulse.
    input wire logic done_out, // Done pulse.
    input wire logic illegal_out, // Illegal pulse.
    input wire logic cc_update_out, // Flag pulse.
    input wire logic [3:0] cond_codes_out // Flags.
);
    logic is_set, is_ar, ovf;
    logic [5:0] x3;
    logic [31:0] opa, opb, sum;
    // Decode the offered word; register zero reads as zero on both operands.
    assign x3 = instr_word_in[24:19];
    assign is_set = instr_valid_in && instr_word_in[31:30] == ILSA_OP_FMT2
        && instr_word_in[24:22] == ILSA_FMT2_SETHIGH;
    assign is_ar = instr_valid_in && instr_word_in[31:30] == ILSA_OP_ARITH;
    assign opa = (instr_word_in[18:14] == 5'h00) ? 32'h0 : first_source_data_in;
    assign opb = instr_word_in[13] ? {{19{instr_word_in[12]}}, instr_word_in[12:0]}
        : (instr_word_in[4:0] == 5'h00) ? 32'h0 : second_source_data_in;
    assign sum = opa + opb;
    assign ovf = opa[31] == opb[31] && sum[31] != opa[31];

    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!rstn_in);

    src_index_a: assert property (first_source_reg_out == instr_word_in[18:14]
        && second_source_reg_out == instr_word_in[4:0]) else $error("source index wrong");
    dest_zero_a: assert property (write_en_out |-> dest_reg_out != 5'h00)
        else $error("write to register zero");
    set_high_value_a: assert property ($past(is_set) |-> done_out
        && result_out == {$past(instr_word_in[21:0]), 10'h000}) else $error("set-high value");
    set_high_cc_a: assert property ($past(is_set) |-> !cc_update_out
        && cond_codes_out == $past(cond_codes_out)) else $error("set-high changed flags");
    plain_cc_a: assert property ($past(is_ar && !x3[4]) |-> !cc_update_out)
        else $error("plain form updated flags");
    shift_cc_a: assert property ($past(is_ar && x3 inside {[6'h25:6'h27]})
        |-> $stable(cond_codes_out)) else $error("shift changed flags");
    add_sum_a: assert property ($past(is_ar && x3 == ILSA_XOPC_ADD) |->
        result_out == $past(sum)) else $error("add sum wrong");
    add_ovf_a: assert property ($past(is_ar && x3 == ILSA_XOPC_ADDCC) |-> cc_update_out
        && cond_codes_out[ILSA_CC_V] == $past(ovf)) else $error("add overflow wrong");
    idle_quiet_a: assert property (!$past(instr_valid_in) |-> !done_out
        && !write_en_out && !cc_update_out) else $error("pulse without instruction");
    illegal_quiet_a: assert property (illegal_out |-> !done_out && !write_en_out
        && !cc_update_out) else $error("illegal encoding had an effect");
endmodule : ilsa_unit_checker

bind ilsa_unit ilsa_unit_checker u_chk (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in),
    .instr_valid_in(instr_valid_in), .instr_word_in(instr_word_in),
    .first_source_data_in(first_source_data_in), .second_source_data_in(second_source_data_in),
    .first_source_reg_out(first_source_reg_out), .second_source_reg_out(second_source_reg_out),
    .result_out(result_out), .dest_reg_out(dest_reg_out), .write_en_out(write_en_out),
    .done_out(done_out), .illegal_out(illegal_out), .cc_update_out(cc_update_out),
    .cond_codes_out(cond_codes_out));

// file: tb/ilsa_regfile_model.sv
`timescale 1ns/1ps
module ilsa_regfile_model (
    input wire logic clk_in, // Clock.
    input wire logic [4:0] idx_a_in, // First read index.
    input wire logic [4:0] idx_b_in, // Second read index.
    input wire logic wr_en_in, // Write strobe.
    input wire logic [4:0] wr_idx_in, // Write index.
    input wire logic [31:0] wr_data_in, // Write data.
    output logic [31:0] data_a_out, // First read data.
    output logic [31:0] data_b_out // Second read data.
);
    logic [31:0] regs_q [32];
    // Register zero always reads zero whatever was stored.
    assign data_a_out = (idx_a_in == 5'h00) ? 32'h0 : regs_q[idx_a_in];
    assign data_b_out = (idx_b_in == 5'h00) ? 32'h0 : regs_q[idx_b_in];
    // Writes to register zero are dropped.
    always @(posedge clk_in) begin
        if (wr_en_in && wr_idx_in != 5'h00) begin
            regs_q[wr_idx_in] <= wr_data_in;
        end
    end
endmodule : ilsa_regfile_model

// file: tb/ilsa_unit_tb_top.sv
`timescale 1ns/1ps
module ilsa_unit_tb_top;
    import ilsa_pkg::*;
    logic clk_sys_in = 1'b0;
    logic rstn_in = 1'b0;
    logic instr_valid_in = 1'b0;
    logic [31:0] instr_word_in = 32'h0;
    logic [31:0] rd1, rd2, res;
    logic [4:0] idx1, idx2, dest;
    logic we, done, ill, ccu;
    logic [3:0] cc, cc_exp;
    int err_total = 0;
    int samples_checked = 0;

    ilsa_unit DUT (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .instr_valid_in(instr_valid_in),
        .instr_word_in(instr_word_in), .first_source_data_in(rd1), .second_source_data_in(rd2),
        .first_source_reg_out(idx1), .second_source_reg_out(idx2), .result_out(res),
        .dest_reg_out(dest), .write_en_out(we), .done_out(done), .illegal_out(ill),
        .cc_update_out(ccu), .cond_codes_out(cc));
    ilsa_regfile_model PM (.clk_in(clk_sys_in), .idx_a_in(idx1), .idx_b_in(idx2),
        .wr_en_in(we), .wr_idx_in(dest), .wr_data_in(res), .data_a_out(rd1), .data_b_out(rd2));

    // Free-running system clock.
    initial begin
        forever #5 clk_sys_in = ~clk_sys_in;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // One instruction for one cycle; the answer is settled when this returns.
    task automatic issue(input logic [31:0] w);
        @(posedge clk_sys_in);
        #1 instr_valid_in = 1'b1;
        instr_word_in = w;
        @(posedge clk_sys_in);
        #1 instr_valid_in = 1'b0;
    endtask : issue

    // Runs one format-3 operation on r1 and r2 or an immediate into r3.
    task automatic exec(input logic [5:0] f, input logic i, input logic [12:0] imm,
        input logic [31:0] a, input logic [31:0] b);
        logic [31:0] y, r;
        logic [32:0] s;
        logic v, c;
        PM.regs_q[1] = a;
        PM.regs_q[2] = b;
        y = i ? {{19{imm[12]}}, imm} : b;
        v = 1'b0;
        c = 1'b0;
        case (f & 6'h2F)
            6'h00, 6'h08: begin
                s = {1'b0, a} + {1'b0, y} + {32'h0, f[3] & cc_exp[0]};
                r = s[31:0];
                v = a[31] == y[31] && r[31] != a[31];
                c = s[32];
            end
            6'h01: r = a & y;
            6'h02: r = a | y;
            6'h03: r = a ^ y;
            6'h05: r = a & ~y;
            6'h06: r = a | ~y;
            6'h07: r = a ^ ~y;
            6'h25: r = a << y[4:0];
            6'h26: r = a >> y[4:0];
            default: r = $signed(a) >>> y[4:0];
        endcase
        if (f[4]) cc_exp = {r[31], r == 32'h0, v, c};
        issue({2'b10, 5'd3, f, 5'd1, i, i ? imm : 13'h0002});
        chk(res, r);
        chk({28'h0, done, we, ill, ccu}, {28'h0, 3'h6, f[4]});
        chk(32'(cc), 32'(cc_exp));
    endtask : exec

    task automatic t_logic();
        logic [5:0] ops [6] = '{6'h01, 6'h02, 6'h03, 6'h05, 6'h06, 6'h07};
        for (int k = 0; k < 6; k++) begin
            for (int m = 0; m < 4; m++) begin
                exec(ops[k] | (m[0] ? 6'h10 : 6'h00), m[1], 13'h1F0F, 32'hA5C30FF0,
                    32'h3C3CF00F);
            end
        end
        exec(6'h11, 1'b0, 13'h0, 32'hF0F0F0F0, 32'h0F0F0F0F);
    endtask : t_logic

    task automatic t_add();
        exec(6'h00, 1'b0, 13'h0, 32'h7FFFFFFF, 32'h1);
        exec(6'h10, 1'b0, 13'h0, 32'h7FFFFFFF, 32'h1);
        exec(6'h10, 1'b0, 13'h0, 32'hFFFFFFFF, 32'h1);
        exec(6'h08, 1'b0, 13'h0, 32'h5, 32'h6);
        exec(6'h18, 1'b1, 13'h1FFF, 32'h0, 32'h0);
        exec(6'h10, 1'b1, 13'h1000, 32'h80000000, 32'h0);
    endtask : t_add

    task automatic t_sethi();
        issue({2'b00, 5'd4, 3'b100, 22'h3ABCDE});
        chk(res, {22'h3ABCDE, 10'h000});
        chk({27'h0, dest}, 32'h4);
        chk({29'h0, done, we, ccu}, 32'h6);
        chk(32'(cc), 32'(cc_exp));
        issue(32'h01000000);
        chk({29'h0, done, we, ccu}, 32'h4);
        chk(32'(cc), 32'(cc_exp));
        issue(32'h40000000);
        chk({29'h0, done, we, ill}, 32'h0);
    endtask : t_sethi

    task automatic t_shift();
        for (int k = 5; k < 8; k++) begin
            exec(6'h20 | 6'(k), 1'b0, 13'h0, 32'h8421F00D, 32'hFFFFFFE4);
            exec(6'h20 | 6'(k), 1'b1, 13'h0000, 32'h8421F00D, 32'h0);
            exec(6'h20 | 6'(k), 1'b1, 13'h001F, 32'h8421F00D, 32'h0);
        end
        issue({2'b10, 5'd3, 6'h25, 5'd1, 1'b1, 13'h0024});
        chk({29'h0, we, ill, ccu}, 32'h2);
        issue({2'b10, 5'd3, 6'h35, 5'd1, 1'b0, 13'h0002});
        chk({29'h0, we, ill, ccu}, 32'h2);
    endtask : t_shift

    task automatic wrap_up();
        if (err_total == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : wrap_up

    // Main sequence: reset, then each group of operations.
    initial begin
        cc_exp = 4'h0;
        repeat (3) @(posedge clk_sys_in);
        #1 rstn_in = 1'b1;
        repeat (3) @(posedge clk_sys_in);
        #1 chk(32'(cc), 32'(ILSA_CC_RESET));
        t_logic();
        t_add();
        t_sethi();
        t_shift();
        wrap_up();
    end

    // Watchdog cuts a hang short well beyond the expected run.
    initial begin
        #20000;
        err_total++;
        wrap_up();
    end
endmodule : ilsa_unit_tb_top
